// >>> udc_consts.svh
// Constants for the cascadable 4-bit up/down counter
`ifndef UDC_CONSTS_SVH
`define UDC_CONSTS_SVH

`define UDC_CNT_W 4
`define UDC_CNT_MAX 4'hF
`define UDC_CNT_ZERO 4'h0
`define UDC_CNT_STEP 4'h1
`define UDC_CNT_RESET 4'h0
`define UDC_PINS_W 8
// Preset load high, inhibit high, clock low: a quiet pin state
`define UDC_PINS_RESET 8'h0C
`define UDC_TC_RESET 1'b0
`define UDC_RC_RESET 1'b1

`endif

// >>> udc_pkg.sv
// Types shared by the cascadable up/down counter
`default_nettype none
package udc_pkg;

	typedef struct packed
	{
		logic [3:0] preset_value;
		logic preset_load_n;
		logic count_inhibit;
		logic direction_sel;
		logic count_clock;
	} udc_pins_t;

	typedef enum logic [1:0] {UDC_HOLD, UDC_UP, UDC_DOWN, UDC_PRESET} udc_mode_t;

endpackage
`default_nettype wire

// >>> udc_counter.sv
// Cascadable 4-bit up/down counter with terminal flag and ripple carry
`timescale 1ns/100ps
`include "udc_consts.svh"
`default_nettype none
module udc_counter
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Counter pins from the driving logic
	input wire logic count_clock,
	input wire logic preset_load_n,
	input wire logic count_inhibit,
	input wire logic direction_sel,
	input wire logic [3:0] preset_value,
	// Counter outputs
	output logic [3:0] count_value,
	output logic terminal_flag,
	output logic carry_pulse_n
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	udc_pkg::udc_pins_t pins_in;
	logic [`UDC_PINS_W-1:0] s1_reg, s2_reg, s3_reg;
	logic [`UDC_PINS_W-1:0] stab_bits_reg, stab_bits_next;
	udc_pkg::udc_pins_t stab_reg, stab_next;

	assign pins_in = '{preset_value: preset_value, preset_load_n: preset_load_n,
		count_inhibit: count_inhibit, direction_sel: direction_sel, count_clock: count_clock};

	// A pin level is accepted only once the second and third stages agree
	// Costs four clk_sys cycles of latency; a pin pulse shorter than two cycles may be lost
	genvar gi;
	generate
		for (gi = 0; gi < `UDC_PINS_W; gi++)
		begin : g_filt
			assign stab_bits_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : stab_bits_reg[gi];
		end
	endgenerate

	assign stab_reg = udc_pkg::udc_pins_t'(stab_bits_reg);
	assign stab_next = udc_pkg::udc_pins_t'(stab_bits_next);

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_reg <= `UDC_PINS_RESET;
			s2_reg <= `UDC_PINS_RESET;
			s3_reg <= `UDC_PINS_RESET;
			stab_bits_reg <= `UDC_PINS_RESET;
		end
		else
		begin
			s1_reg <= pins_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			stab_bits_reg <= stab_bits_next;
		end
	end

	// ----------------------------------------
	// Terminal decode
	// ----------------------------------------
	function automatic logic tc_decode(input logic [3:0] cnt, input logic down);
		tc_decode = down ? (cnt == `UDC_CNT_ZERO) : (cnt == `UDC_CNT_MAX);
	endfunction

	// ----------------------------------------
	// Count state
	// ----------------------------------------
	logic [3:0] count_reg, count_next;
	logic tc_reg, tc_next;
	logic rc_n_reg, rc_n_next;
	logic clk_rise;
	udc_pkg::udc_mode_t mode;

	// Mode comes from the filtered pins only, so no half-settled pin can steer the count
	assign clk_rise = stab_next.count_clock && !stab_reg.count_clock;

	always_comb
	begin
		// Preset is level driven and needs no clock edge
		if (!stab_next.preset_load_n)
			mode = udc_pkg::UDC_PRESET;
		else if (stab_next.count_inhibit || !clk_rise)
			mode = udc_pkg::UDC_HOLD;
		else if (stab_next.direction_sel)
			mode = udc_pkg::UDC_DOWN;
		else
			mode = udc_pkg::UDC_UP;
		unique case (mode)
			udc_pkg::UDC_PRESET: count_next = stab_next.preset_value;
			udc_pkg::UDC_UP: count_next = count_reg + `UDC_CNT_STEP;
			udc_pkg::UDC_DOWN: count_next = count_reg - `UDC_CNT_STEP;
			udc_pkg::UDC_HOLD: count_next = count_reg;
		endcase
		// Flag follows count and direction alone; it holds while both hold
		tc_next = tc_decode(count_next, stab_next.direction_sel);
		// Low only through the clock's low phase with everything enabled
		rc_n_next = !(!stab_next.count_clock && !stab_next.count_inhibit
			&& tc_next && stab_next.preset_load_n);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			count_reg <= `UDC_CNT_RESET;
			tc_reg <= `UDC_TC_RESET;
			rc_n_reg <= `UDC_RC_RESET;
		end
		else
		begin
			count_reg <= count_next;
			tc_reg <= tc_next;
			rc_n_reg <= rc_n_next;
		end
	end

	// Outputs come straight from registers, so the flag carries no decoding spikes
	assign count_value = count_reg;
	assign terminal_flag = tc_reg;
	assign carry_pulse_n = rc_n_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Checks watch the filtered pins, because the raw pins may move between clk_sys edges

	AST_PRESET_LOADS:
		assert property (!stab_next.preset_load_n |=> count_reg == $past(stab_next.preset_value))
		else $error("preset value not loaded");

	AST_INHIBIT_HOLDS:
		assert property (stab_next.preset_load_n && stab_next.count_inhibit |=> $stable(count_reg))
		else $error("count moved while inhibited");

	AST_NO_EDGE_HOLDS:
		assert property (stab_next.preset_load_n && !clk_rise |=> $stable(count_reg))
		else $error("count moved without a rising clock");

	AST_COUNT_UP:
		assert property (clk_rise && stab_next.preset_load_n && !stab_next.count_inhibit
			&& !stab_next.direction_sel |=> count_reg == 4'($past(count_reg) + 4'h1))
		else $error("up count wrong");

	AST_COUNT_DOWN:
		assert property (clk_rise && stab_next.preset_load_n && !stab_next.count_inhibit
			&& stab_next.direction_sel |=> count_reg == 4'($past(count_reg) - 4'h1))
		else $error("down count wrong");

	AST_WRAP_UP:
		assert property (count_reg == 4'hF && clk_rise && stab_next.preset_load_n
			&& !stab_next.count_inhibit && !stab_next.direction_sel |=> count_reg == 4'h0)
		else $error("no wrap from 15 to 0");

	AST_TC_DECODE:
		assert property (tc_reg == (stab_reg.direction_sel ? (count_reg == 4'h0) : (count_reg == 4'hF)))
		else $error("terminal flag decode wrong");

	AST_TC_STICKS:
		assert property (tc_reg && $stable(count_next) && $stable(stab_next.direction_sel) |=> tc_reg)
		else $error("terminal flag dropped without a change");

	AST_RC_SUPPRESSED:
		assert property (stab_reg.count_inhibit || !tc_reg || !stab_reg.preset_load_n |-> carry_pulse_n)
		else $error("carry pulse not suppressed");

	AST_RC_LOW_PHASE:
		assert property (!stab_reg.count_clock && !stab_reg.count_inhibit && tc_reg
			&& stab_reg.preset_load_n |-> !carry_pulse_n)
		else $error("carry pulse missing in clock low phase");

	AST_WRAP_DOWN:
		assert property (count_reg == 4'h0 && clk_rise && stab_next.preset_load_n
			&& !stab_next.count_inhibit && stab_next.direction_sel |=> count_reg == 4'hF)
		else $error("no wrap from 0 to 15");

	AST_PRESET_OVERRIDES_EDGE:
		assert property (!stab_next.preset_load_n && clk_rise
			|=> count_reg == $past(stab_next.preset_value))
		else $error("clock edge overrode the preset");

	// A count change without preset must trace back to an accepted rising edge
	AST_CHANGE_NEEDS_EDGE:
		assert property ($changed(count_reg) && $past(stab_next.preset_load_n)
			|-> $past(clk_rise) && !$past(stab_next.count_inhibit))
		else $error("count changed without an enabled rising clock");

	AST_STEP_OF_ONE:
		assert property ($changed(count_reg) && $past(stab_next.preset_load_n)
			|-> count_reg == 4'($past(count_reg) + 4'h1) || count_reg == 4'($past(count_reg) - 4'h1))
		else $error("count moved by more than one step");

	AST_INHIBIT_KEEPS_FLAG:
		assert property (stab_next.preset_load_n && stab_next.count_inhibit
			&& $stable(stab_next.direction_sel) |=> $stable(tc_reg))
		else $error("terminal flag moved while inhibited");

	AST_TC_ONLY_AT_ENDS:
		assert property (tc_reg |-> count_reg == 4'h0 || count_reg == 4'hF)
		else $error("terminal flag away from the ends of the range");

	AST_TC_IGNORES_INHIBIT:
		assert property ($changed(stab_reg.count_inhibit) && $stable(count_reg)
			&& $stable(stab_reg.direction_sel) |-> $stable(tc_reg))
		else $error("terminal flag moved with the inhibit");

	AST_RC_HIGH_WITH_CLOCK:
		assert property (stab_reg.count_clock |-> carry_pulse_n)
		else $error("carry pulse low while the count clock is high");

	AST_RC_STARTS_AT_FALL:
		assert property ($fell(stab_reg.count_clock) && !stab_reg.count_inhibit && tc_reg
			&& stab_reg.preset_load_n |-> $fell(carry_pulse_n))
		else $error("carry pulse did not start at the clock fall");

	AST_RC_PRESET_HIGH:
		assert property (!stab_reg.preset_load_n |-> carry_pulse_n)
		else $error("carry pulse low during preset");

endmodule
`default_nettype wire

// >>> udc_driver.sv
// Partner model: the driving logic in front of the counter pins
`timescale 1ns/100ps
`default_nettype none
module udc_driver
(
	// Clock
	input wire logic clk_sys,
	// Pins to the counter
	output var udc_pkg::udc_pins_t pins
);
	initial
	begin
		pins = 8'h0C;
	end
	// Levels move at clk_sys edges only, whatever the count clock level
	task automatic set(input logic [3:0] v, input logic pl, input logic inh, input logic dir);
		@(posedge clk_sys);
		pins <= {v, pl, inh, dir, pins.count_clock};
		repeat (5) @(posedge clk_sys);
	endtask
	// Long low phase leaves room for a rippled carry; the flag never clocks us
	task automatic pulse();
		@(posedge clk_sys);
		pins.count_clock <= 1'b1;
		repeat (6) @(posedge clk_sys);
		pins.count_clock <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// >>> updown_counter_4bit_cascadable_test.sv
// Self-checking bench for the cascadable up/down counter
`timescale 1ns/100ps
`default_nettype none
module updown_counter_4bit_cascadable_test;
	logic clk_sys;
	logic rstn;
	udc_pkg::udc_pins_t pins;
	logic [3:0] count_value;
	logic terminal_flag;
	logic carry_pulse_n;
	logic [3:0] exp_cnt;
	logic exp_pl;
	logic exp_inh;
	logic exp_dir;
	int mismatches;
	int checks_done;
	udc_driver u_drv (.clk_sys(clk_sys), .pins(pins));
	udc_counter u_dut (.clk_sys(clk_sys), .rstn(rstn), .count_clock(pins.count_clock),
		.preset_load_n(pins.preset_load_n), .count_inhibit(pins.count_inhibit),
		.direction_sel(pins.direction_sel), .preset_value(pins.preset_value),
		.count_value(count_value), .terminal_flag(terminal_flag), .carry_pulse_n(carry_pulse_n));
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check4(input string what, input logic [3:0] e, input logic [3:0] g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic check1(input string what, input logic e, input logic g);
		check4(what, {3'h0, e}, {3'h0, g});
	endtask
	task automatic check_all();
		logic tf;
		tf = exp_dir ? (exp_cnt == 4'h0) : (exp_cnt == 4'hF);
		#1;
		check4("count_value", exp_cnt, count_value);
		check1("terminal_flag", tf, terminal_flag);
		check1("carry_pulse_n", !(tf && !exp_inh && exp_pl), carry_pulse_n);
	endtask
	task automatic put(input logic [3:0] v, input logic pl, input logic inh, input logic dir);
		u_drv.set(v, pl, inh, dir);
		exp_pl = pl;
		exp_inh = inh;
		exp_dir = dir;
		if (!pl)
			exp_cnt = v;
		check_all();
	endtask
	task automatic step();
		u_drv.pulse();
		if (exp_pl && !exp_inh)
			exp_cnt = exp_dir ? exp_cnt - 4'h1 : exp_cnt + 4'h1;
		check_all();
	endtask
	task automatic t_preset();
		put(4'hF, 1'b0, 1'b0, 1'b0);
		step();
		put(4'hF, 1'b1, 1'b0, 1'b0);
	endtask
	task automatic t_up();
		step();
		step();
	endtask
	task automatic t_inhibit();
		put(4'h1, 1'b1, 1'b1, 1'b0);
		step();
		put(4'hF, 1'b0, 1'b1, 1'b0);
		put(4'hF, 1'b1, 1'b1, 1'b0);
	endtask
	task automatic t_down();
		put(4'h1, 1'b0, 1'b0, 1'b1);
		put(4'h1, 1'b1, 1'b0, 1'b1);
		step();
		step();
		put(4'hF, 1'b1, 1'b0, 1'b0);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#100000;
		mismatches++;
		summarize();
	end
	initial
	begin
		rstn = 1'b0;
		mismatches = 0;
		checks_done = 0;
		exp_cnt = 4'h0;
		exp_pl = 1'b1;
		exp_inh = 1'b1;
		exp_dir = 1'b0;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		check_all();
		t_preset();
		t_up();
		t_inhibit();
		t_down();
		summarize();
	end
endmodule
`default_nettype wire
